// >>> common/pth_consts.svh
// Purpose: Constants for the period timer with hardware limit.
// Assumes: Included by the timer module only.
// Notes: Register offsets are word addresses on the bus.
//
// Behaviour
// - Count increments each tick; period match signals postscaler, count clears.
// - Gated mode halts while gate inactive, resumes from held count.
// - Device reset clears count and presets period to all ones.
// - Prescaler and postscaler clear on count write, control write, resets.
// - Control register write leaves count unchanged.
// - Free-running match returns count to zero next tick, advances postscaler.
// - Postscale count equal to select gives one-tick pulse and clears.
// - One-shot match clears run enable and stops until re-enabled.
// - Monostable match keeps run enable; new external event restarts.
// - External triggers ignored while debug freeze is active.
// - Codes 000 software run, 001 gate high, 010 gate low.
// - Codes 011 any edge, 100 rising, 101 falling edge reset.
// - Code 110 resets while low, 111 while high.
// - One-shot 000 software start; 001-011 rising, falling, any edge start.
// - One-shot 100/101 edge start and reset; 110/111 edge start, level reset.
// - Monostable 001-011 edge start; match stops at zero, keeps enable.
// - Group 10 codes 110/111 level start, opposite level reset, one-shot.
// - One-shot tick after match clears run enable, count stops at zero.
// - Edge-started modes need fresh edge after run enable is set again.
// - Postscaler advances each match; its output offered to other modules.
// - Interrupt flag raised when postscaler reaches selected ratio 1..16.
// - Hardware-limit one-shot resumes counting three ticks after reset edge.
`ifndef PTH_CONSTS_SVH
`define PTH_CONSTS_SVH

// ==========================================================
// Register map
`define PTH_OFS_COUNT 4'h0
`define PTH_OFS_PERIOD 4'h1
`define PTH_OFS_CTRL 4'h2
`define PTH_OFS_MODE 4'h3
`define PTH_OFS_STAT 4'h4

// ==========================================================
// Reset values and field positions
`define PTH_COUNT_RST 8'h00
`define PTH_PERIOD_RST 8'hff
`define PTH_CTRL_ON 7
`define PTH_CTRL_PRE_HI 6
`define PTH_CTRL_PRE_LO 4
`define PTH_CTRL_POST_HI 3
`define PTH_CTRL_POST_LO 0
`define PTH_MODE_HI 4
`define PTH_MODE_LO 0
`define PTH_MODE_FREEZE 7
`define PTH_RESTART_DLY 2'h2

`endif

// >>> common/pth_pkg.sv
// Purpose: Types for the period timer with hardware limit.
// Assumes: Constants come from pth_consts.svh.
// Notes: Mode groups follow the upper two mode bits.
package pth_pkg;

  // ==========================================================
  // Mode groups
  typedef enum logic [1:0] {
    PTH_GRP_FREE = 2'b00,
    PTH_GRP_ONESHOT = 2'b01,
    PTH_GRP_MONO = 2'b10,
    PTH_GRP_RSVD = 2'b11
  } pth_grp_e;

  // Run state of the start logic
  typedef enum logic [1:0] {
    PTH_ST_IDLE = 2'b00,
    PTH_ST_ARMED = 2'b01,
    PTH_ST_RUN = 2'b10,
    PTH_ST_WAIT = 2'b11
  } pth_st_e;

  // Avalon-MM request bundle
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } pth_req_s;

  // Decoded external input events
  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } pth_ers_s;

endpackage

// >>> logic/pth_timer.sv
// Purpose: 8-bit period timer with hardware limit and Avalon-MM registers.
// Assumes: Single clock; external reset input synchronous to core_clk.
// Notes: Prescaler makes a one-cycle tick enable; interrupt flag set on postscaler hit.
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "pth_consts.svh"

module pth_timer
  import pth_pkg::*;
#(
  parameter int PRE_W = 7
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire pth_req_s avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ers_in,
  input wire logic dbg_freeze,
  output logic postscaled_pulse,
  output logic period_match,
  output logic [7:0] count_out,
  output logic timer_flag
);

  // Elaboration check on prescaler width
  if (PRE_W < 1 || PRE_W > 7) begin : g_chk
    $error("PRE_W must be 1..7");
  end

  // ==========================================================
  // Registers
  logic [7:0] count_r, count_nxt;
  logic [7:0] period_r;
  logic [7:0] ctrl_r;
  logic [7:0] mode_r;
  logic [6:0] pre_r, pre_nxt;
  logic [3:0] post_r, post_nxt;
  logic ers_s1_r, ers_s2_r, ers_d_r;
  pth_st_e st_r, st_nxt;
  logic [1:0] dly_r, dly_nxt;
  logic match_r;
  logic pulse_r, flag_r, ack_r, wreq_r;
  logic [31:0] rdata_r;
  logic on_clr;

  // ==========================================================
  // Bus decode
  wire acc = (avs_req.read | avs_req.write) & ~ack_r;
  // Write lands only at the edge where waitrequest is seen low
  wire wr = avs_req.write & ack_r;
  wire wr_count = wr & (avs_req.address == `PTH_OFS_COUNT);
  wire wr_period = wr & (avs_req.address == `PTH_OFS_PERIOD);
  wire wr_ctrl = wr & (avs_req.address == `PTH_OFS_CTRL);
  wire wr_mode = wr & (avs_req.address == `PTH_OFS_MODE);
  wire [7:0] wd = avs_req.writedata[7:0];

  // Control fields
  wire run_en = ctrl_r[`PTH_CTRL_ON];
  wire [2:0] pre_sel = ctrl_r[`PTH_CTRL_PRE_HI:`PTH_CTRL_PRE_LO];
  wire [3:0] post_sel = ctrl_r[`PTH_CTRL_POST_HI:`PTH_CTRL_POST_LO];
  wire [4:0] mode = mode_r[`PTH_MODE_HI:`PTH_MODE_LO];
  wire freeze = dbg_freeze | mode_r[`PTH_MODE_FREEZE];
  pth_grp_e grp;
  assign grp = pth_grp_e'(mode[4:3]);
  wire [2:0] sub = mode[2:0];

  // Prescaler: tick when low bits all ones (ratio 1:2^pre_sel)
  function automatic logic pre_tick(input logic [6:0] p,
                                    input logic [2:0] s);
    logic [6:0] m;
    m = 7'h7f >> (3'h7 - s);
    pre_tick = ((p & m) == m);
  endfunction
  wire tick = pre_tick(pre_r, pre_sel);

  // External input events, freeze masks them
  pth_ers_s ev;
  assign ev.lvl = ers_s2_r;
  assign ev.rise = tick & ~freeze & ers_s2_r & ~ers_d_r;
  assign ev.fall = tick & ~freeze & ~ers_s2_r & ers_d_r;
  wire any_e = ev.rise | ev.fall;
  wire lvl_ok = ~freeze;

  // Start edge per sub code
  wire st_edge = (sub == 3'h1 || sub == 3'h4 || sub == 3'h6) ? ev.rise :
                 (sub == 3'h2 || sub == 3'h5 || sub == 3'h7) ? ev.fall :
                 any_e;
  wire edge_start = (grp == PTH_GRP_ONESHOT && sub != 3'h0) ||
                    (grp == PTH_GRP_MONO && sub <= 3'h3);

  // Level reset and level start in group 10 codes 110/111
  wire lvl_grp = grp == PTH_GRP_MONO && sub[2:1] == 2'b11;
  wire lvl_go = lvl_ok & (sub[0] ? ~ev.lvl : ev.lvl);

  // Reserved codes
  wire rsvd = grp == PTH_GRP_RSVD ||
              (grp == PTH_GRP_MONO && (sub == 3'h0 || sub == 3'h4 ||
               sub == 3'h5));

  // Hardware reset of count
  logic hw_rst;
  always_comb begin
    hw_rst = 1'b0;
    if (grp == PTH_GRP_FREE) begin
      unique case (sub)
        3'h3: hw_rst = any_e;
        3'h4: hw_rst = ev.rise;
        3'h5: hw_rst = ev.fall;
        3'h6: hw_rst = lvl_ok & ~ev.lvl;
        3'h7: hw_rst = lvl_ok & ev.lvl;
        default: hw_rst = 1'b0;
      endcase
    end else if (grp == PTH_GRP_ONESHOT && st_r != PTH_ST_ARMED) begin
      unique case (sub)
        3'h4: hw_rst = ev.rise;
        3'h5: hw_rst = ev.fall;
        3'h6: hw_rst = lvl_ok & ~ev.lvl;
        3'h7: hw_rst = lvl_ok & ev.lvl;
        default: hw_rst = 1'b0;
      endcase
    end else if (lvl_grp) begin
      hw_rst = lvl_ok & ~lvl_go;
    end
  end

  // Gate for free-running group
  wire gate = grp != PTH_GRP_FREE ? 1'b1 :
              sub == 3'h1 ? ev.lvl :
              sub == 3'h2 ? ~ev.lvl : 1'b1;

  wire match = count_r == period_r;
  wire one_shot = grp == PTH_GRP_ONESHOT || lvl_grp;

  // Run state machine
  always_comb begin
    st_nxt = st_r;
    dly_nxt = dly_r;
    unique case (st_r)
      PTH_ST_IDLE: begin
        if (run_en && !rsvd) begin
          st_nxt = edge_start ? PTH_ST_ARMED : PTH_ST_RUN;
        end
      end
      PTH_ST_ARMED: begin
        if (st_edge) begin
          st_nxt = PTH_ST_RUN;
        end
      end
      PTH_ST_RUN: begin
        if (tick && match && grp == PTH_GRP_MONO && !lvl_grp) begin
          st_nxt = PTH_ST_ARMED;
        end else if (tick && hw_rst && grp == PTH_GRP_ONESHOT &&
                     sub[2:1] == 2'b10) begin
          st_nxt = PTH_ST_WAIT;
          dly_nxt = `PTH_RESTART_DLY;
        end
      end
      PTH_ST_WAIT: begin
        if (tick) begin
          dly_nxt = dly_r - 2'h1;
          if (dly_r == 2'h1) begin
            st_nxt = PTH_ST_RUN;
          end
        end
      end
    endcase
    if (!run_en || rsvd || wr_mode) begin
      st_nxt = PTH_ST_IDLE;
    end
  end

  wire running = st_r == PTH_ST_RUN && gate && !rsvd && run_en;
  wire inc_tick = tick & running & ~hw_rst;
  wire match_ev = inc_tick & match;
  assign on_clr = match_ev & one_shot;

  // Count next value
  always_comb begin
    count_nxt = count_r;
    if (wr_count) begin
      count_nxt = wd;
    end else if (tick && hw_rst && !rsvd && run_en) begin
      count_nxt = `PTH_COUNT_RST;
    end else if (match_ev) begin
      count_nxt = `PTH_COUNT_RST;
    end else if (inc_tick) begin
      count_nxt = count_r + 8'h01;
    end
  end

  // Prescaler and postscaler next values
  wire scl_clr = wr_count | wr_ctrl | (tick & hw_rst);
  wire post_hit = match_ev & (post_r == post_sel);
  always_comb begin
    pre_nxt = pre_r + 7'h01;
    post_nxt = post_r;
    if (match_ev) begin
      post_nxt = post_hit ? 4'h0 : post_r + 4'h1;
    end
    if (scl_clr) begin
      pre_nxt = 7'h00;
      post_nxt = 4'h0;
    end
  end

  // Read mux
  logic [7:0] rsel;
  always_comb begin
    rsel = 8'h00;
    unique case (avs_req.address)
      `PTH_OFS_COUNT: rsel = count_r;
      `PTH_OFS_PERIOD: rsel = period_r;
      `PTH_OFS_CTRL: rsel = ctrl_r;
      `PTH_OFS_MODE: rsel = mode_r;
      `PTH_OFS_STAT: rsel = {5'h00, st_r, flag_r};
      default: rsel = 8'h00;
    endcase
  end

  // ==========================================================
  // Timer state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count_r <= `PTH_COUNT_RST;
      period_r <= `PTH_PERIOD_RST;
      pre_r <= 7'h00;
      post_r <= 4'h0;
      st_r <= PTH_ST_IDLE;
      dly_r <= 2'h0;
    end else begin
      count_r <= count_nxt;
      pre_r <= pre_nxt;
      post_r <= post_nxt;
      st_r <= st_nxt;
      dly_r <= dly_nxt;
      if (wr_period) begin
        period_r <= wd;
      end
    end
  end

  // Control and mode registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_r <= 8'h00;
      mode_r <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wd;
      end else if (on_clr) begin
        ctrl_r[`PTH_CTRL_ON] <= 1'b0;
      end
      if (wr_mode) begin
        mode_r <= wd;
      end
    end
  end

  // Input synchroniser and edge history
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ers_s1_r <= 1'b0;
      ers_s2_r <= 1'b0;
      ers_d_r <= 1'b0;
    end else begin
      ers_s1_r <= ers_in;
      ers_s2_r <= ers_s1_r;
      if (tick) begin
        ers_d_r <= ers_s2_r;
      end
    end
  end

  // Outputs; flag set wins over clear on status write
  wire wr_stat = wr & (avs_req.address == `PTH_OFS_STAT);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pulse_r <= 1'b0;
      match_r <= 1'b0;
      flag_r <= 1'b0;
      ack_r <= 1'b0;
      wreq_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (tick) begin
        pulse_r <= post_hit;
        match_r <= match_ev;
      end
      if (post_hit) begin
        flag_r <= 1'b1;
      end else if (wr_stat && wd[0]) begin
        flag_r <= 1'b0;
      end
      ack_r <= acc;
      wreq_r <= ~acc;
      rdata_r <= {24'h000000, rsel};
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wreq_r;
  assign postscaled_pulse = pulse_r;
  assign period_match = match_r;
  assign count_out = count_r;
  assign timer_flag = flag_r;

endmodule

// >>> test/pth_checker_assertions.sv
// Purpose: Port-level checks for pth_timer.
// Assumes: Any prescale setting; checks hold per tick.
// Notes: Bound to every pth_timer instance.
`timescale 1ns/10ps
module pth_checker
  import pth_pkg::*;
#(
  parameter int PRE_W = 7
)(
  input wire logic core_clk,
  input wire logic reset,
  input wire pth_req_s avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic ers_in,
  input wire logic dbg_freeze,
  input wire logic postscaled_pulse,
  input wire logic period_match,
  input wire logic [7:0] count_out,
  input wire logic timer_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ========
  // Reset and bus handshake
  reset_state_a: assert property (disable iff (1'b0) reset |=>
    count_out == 8'h00 && avs_waitrequest && !timer_flag)
    else $error("state not cleared by reset");
  bus_answer_a: assert property ((avs_req.read || avs_req.write)
    && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered in one cycle");
  bus_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than a cycle");
  hole_zero_a: assert property (!avs_waitrequest && avs_req.read
    && avs_req.address > 4'h4 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  // ========
  // Counting and postscaler
  count_step_a: assert property ($changed(count_out)
    && !$past(avs_req.write) && !$past(avs_req.write, 2)
    |-> count_out == $past(count_out) + 8'h01 || count_out == 8'h00)
    else $error("count moved other than by one or to zero");
  match_clear_a: assert property ($rose(period_match)
    |-> ##[0:1] count_out == 8'h00)
    else $error("count not cleared after match");
  flag_set_a: assert property ($rose(postscaled_pulse)
    |-> ##[0:1] timer_flag)
    else $error("flag not set by postscaled pulse");
  flag_hold_a: assert property (timer_flag && !avs_req.write
    |=> timer_flag)
    else $error("flag dropped without a write");
endmodule
bind pth_timer pth_checker #(.PRE_W(PRE_W)) u_chk (
  .core_clk(core_clk), .reset(reset), .avs_req(avs_req),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ers_in(ers_in), .dbg_freeze(dbg_freeze),
  .postscaled_pulse(postscaled_pulse), .period_match(period_match),
  .count_out(count_out), .timer_flag(timer_flag));

// >>> test/pth_ers_src.sv
// Purpose: Peripheral logic that drives the external reset input.
// Assumes: One tick per core clock in the bench.
// Notes: Every level is held long enough for any trigger kind.
`timescale 1ns/10ps
module pth_ers_src (
  input wire logic core_clk,
  output logic ers_in
);
  localparam int HOLD = 6; // Edge spacing and level width in ticks
  initial ers_in = 1'b0;
  // Drive a new level and keep it for the minimum spacing
  task automatic put(input logic v);
    @(posedge core_clk);
    ers_in <= v;
    repeat (HOLD) @(posedge core_clk);
  endtask
endmodule

// >>> test/period_timer_hw_limit_tb_top.sv
// Purpose: Self-checking bench for pth_timer.
// Assumes: Prescale field zero, except in the prescaler scenario.
// Notes: Registers are reached through Avalon-MM tasks.
`timescale 1ns/10ps
module period_timer_hw_limit_tb_top
  import pth_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  pth_req_s avs_req = '0;
  logic dbg_freeze = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ers_in;
  logic postscaled_pulse;
  logic period_match;
  logic timer_flag;
  logic [7:0] count_out;
  logic [31:0] q;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  int m;
  // ========
  // Clock, design and peripheral source
  always #4 core_clk = ~core_clk;
  pth_timer #(.PRE_W(7)) DUT (.core_clk(core_clk), .reset(reset),
    .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ers_in(ers_in),
    .dbg_freeze(dbg_freeze), .postscaled_pulse(postscaled_pulse),
    .period_match(period_match), .count_out(count_out),
    .timer_flag(timer_flag));
  pth_ers_src ERS (.core_clk(core_clk), .ers_in(ers_in));
  // ========
  // Reporting
  task automatic summarize();
    $display("Compares %0d, failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ========
  // Bus cycle, held until waitrequest is seen low
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_req <= '{address: a, read: !w, write: w, writedata: d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_req <= '0;
  endtask
  task automatic wcnt(input logic [7:0] v);
    n = 0;
    while (count_out !== v && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 600) failures++;
  endtask
  // ========
  // Scenarios
  task automatic t_reset();
    bus(4'h0, 1'b0, 32'h0);
    chk(q, 32'h00);
    bus(4'h1, 1'b0, 32'h0);
    chk(q, 32'hff);
    bus(4'hf, 1'b0, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_free();
    bus(4'h1, 1'b1, 32'h3);
    bus(4'h2, 1'b1, 32'h80);
    wcnt(8'h03);
    @(posedge core_clk);
    chk(count_out, 8'h00);
    @(posedge core_clk);
    chk(count_out, 8'h01);
  endtask
  task automatic t_post();
    bus(4'h2, 1'b1, 32'h82);
    // Skip the start-up transient: count from a pulse on
    n = 0;
    while (postscaled_pulse !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 100) failures++;
    m = 0;
    n = 0;
    repeat (96) begin
      @(posedge core_clk);
      m += period_match;
      n += postscaled_pulse;
    end
    // Period 3: match every 4 ticks; ratio 3: pulse every 12
    chk(m, 32'h18);
    chk(n, 32'h08);
    bus(4'h2, 1'b1, 32'h02);
    bus(4'h4, 1'b0, 32'h0);
    chk(q[0], 1'b1);
    bus(4'h4, 1'b1, 32'h1);
    bus(4'h4, 1'b0, 32'h0);
    chk(q[0], 1'b0);
    bus(4'h0, 1'b1, 32'h2a);
    bus(4'h2, 1'b1, 32'h05);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, 32'h2a);
  endtask
  task automatic t_oneshot();
    bus(4'h3, 1'b1, 32'h08);
    bus(4'h0, 1'b1, 32'h0);
    bus(4'h2, 1'b1, 32'h80);
    wcnt(8'h03);
    repeat (4) @(posedge core_clk);
    bus(4'h2, 1'b0, 32'h0);
    chk(q[7], 1'b0);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_gate();
    logic [31:0] c;
    bus(4'h1, 1'b1, 32'hff);
    bus(4'h3, 1'b1, 32'h01);
    bus(4'h0, 1'b1, 32'h10);
    bus(4'h2, 1'b1, 32'h80);
    repeat (10) @(posedge core_clk);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, 32'h10);
    ERS.put(1'b1);
    ERS.put(1'b0);
    bus(4'h0, 1'b0, 32'h0);
    c = q;
    chk(c > 32'h10, 1'b1);
    repeat (8) @(posedge core_clk);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, c);
  endtask
  task automatic t_edge();
    bus(4'h3, 1'b1, 32'h04);
    bus(4'h2, 1'b1, 32'h80);
    wcnt(8'h40);
    ERS.put(1'b1);
    bus(4'h0, 1'b0, 32'h0);
    chk(q < 32'h10, 1'b1);
    dbg_freeze <= 1'b1;
    ERS.put(1'b0);
    wcnt(8'h40);
    ERS.put(1'b1);
    bus(4'h0, 1'b0, 32'h0);
    chk(q > 32'h40, 1'b1);
    dbg_freeze <= 1'b0;
  endtask
  task automatic t_rsvd();
    logic [31:0] c;
    bus(4'h3, 1'b1, 32'h18);
    bus(4'h2, 1'b1, 32'h80);
    bus(4'h0, 1'b0, 32'h0);
    c = q;
    repeat (10) @(posedge core_clk);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, c);
  endtask
  // Monostable rising-edge start, stop at zero, restart
  task automatic t_mono();
    bus(4'h1, 1'b1, 32'h08);
    bus(4'h3, 1'b1, 32'h11);
    bus(4'h0, 1'b1, 32'h0);
    bus(4'h2, 1'b1, 32'h80);
    repeat (10) @(posedge core_clk);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, 32'h00);
    ERS.put(1'b0);
    ERS.put(1'b1);
    wcnt(8'h08);
    repeat (10) @(posedge core_clk);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, 32'h00);
    bus(4'h2, 1'b0, 32'h0);
    chk(q[7], 1'b1);
    ERS.put(1'b0);
    ERS.put(1'b1);
    bus(4'h0, 1'b0, 32'h0);
    chk(q != 32'h0, 1'b1);
  endtask
  // Free-running count held in reset while input high
  task automatic t_lvl();
    bus(4'h1, 1'b1, 32'hff);
    bus(4'h3, 1'b1, 32'h07);
    bus(4'h0, 1'b1, 32'h30);
    repeat (8) @(posedge core_clk);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, 32'h00);
    ERS.put(1'b0);
    bus(4'h0, 1'b0, 32'h0);
    chk(q != 32'h0, 1'b1);
  endtask
  // Prescale 1:2; captures 22 clocks apart give 11 ticks
  task automatic t_pre();
    logic [31:0] c;
    bus(4'h3, 1'b1, 32'h00);
    bus(4'h2, 1'b1, 32'h90);
    bus(4'h0, 1'b0, 32'h0);
    c = q;
    repeat (19) @(posedge core_clk);
    bus(4'h0, 1'b0, 32'h0);
    chk(q - c, 32'h0b);
  endtask
  // Reset in mid-run restores count, period and control
  task automatic t_mid();
    bus(4'h1, 1'b1, 32'h20);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    bus(4'h1, 1'b0, 32'h0);
    chk(q, 32'hff);
    bus(4'h0, 1'b0, 32'h0);
    chk(q, 32'h00);
    bus(4'h2, 1'b0, 32'h0);
    chk(q, 32'h00);
  endtask
  // ========
  // Main sequence and hang guard
  initial begin
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_free();
    t_post();
    t_oneshot();
    t_gate();
    t_edge();
    t_mono();
    t_lvl();
    t_pre();
    t_mid();
    t_rsvd();
    summarize();
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
endmodule
